// File: core/acp_pkg.sv
/*
  Package for the converter configuration and analog pin-control block.
  Holds register offsets, field positions, reset values, encodings and
  the packed carriers shared by the design. Assumes an 8-bit register
  port with a read answer one cycle after the read strobe.
*/
package acp_pkg;

  // Register offsets on the plain register port.
  localparam logic [1:0] ACP_OFF_CFG = 2'h0;
  localparam logic [1:0] ACP_OFF_PIN_LO = 2'h1;
  localparam logic [1:0] ACP_OFF_PIN_HI = 2'h2;

  // Field positions inside the configuration register.
  localparam int ACP_LOW_POWER_BIT = 7;
  localparam int ACP_DIV_HI = 6;
  localparam int ACP_DIV_LO = 5;
  localparam int ACP_LONG_SAMPLE_BIT = 4;
  localparam int ACP_MODE_HI = 3;
  localparam int ACP_MODE_LO = 2;
  localparam int ACP_CLK_HI = 1;
  localparam int ACP_CLK_LO = 0;

  // Reset values; the bus clock is the default source after reset.
  localparam logic [7:0] ACP_CFG_RST = 8'h00;
  localparam logic [7:0] ACP_PIN_RST = 8'h00;
  localparam logic [7:0] ACP_UNMAPPED_RD = 8'h00;
  localparam int ACP_PINS = 16;
  localparam int ACP_PINS_PER_REG = 8;

  // Divider encodings and the matching counter terminal values.
  localparam logic [1:0] ACP_DIV_1 = 2'h0;
  localparam logic [1:0] ACP_DIV_2 = 2'h1;
  localparam logic [1:0] ACP_DIV_4 = 2'h2;
  localparam logic [1:0] ACP_DIV_8 = 2'h3;
  localparam logic [2:0] ACP_CNT_ONE = 3'h1;
  localparam logic [2:0] ACP_CNT_ZERO = 3'h0;
  localparam logic [2:0] ACP_TERM_DIV1 = 3'h1;
  localparam logic [2:0] ACP_TERM_DIV2 = 3'h2;
  localparam logic [2:0] ACP_TERM_DIV4 = 3'h4;
  // Divide by eight wraps the three-bit counter back to zero.
  localparam logic [2:0] ACP_TERM_DIV8 = 3'h0;

  // Resolution encodings.
  localparam logic [1:0] ACP_MODE_8BIT = 2'h0;
  localparam logic [1:0] ACP_MODE_10BIT = 2'h2;

  // Input clock source encodings.
  localparam logic [1:0] ACP_SRC_BUS = 2'h0;
  localparam logic [1:0] ACP_SRC_BUS_HALF = 2'h1;
  localparam logic [1:0] ACP_SRC_ALT = 2'h2;
  localparam logic [1:0] ACP_SRC_ASYNC = 2'h3;

  // Decoded converter settings handed to the converter core.
  typedef struct packed {
    logic low_power;
    logic long_sample;
    logic ten_bit;
    logic mode_reserved;
    logic [1:0] clock_source;
    logic [1:0] clock_divide;
  } acp_conv_s;

  // Per-pin controls handed to the port logic.
  typedef struct packed {
    logic [15:0] out_hiz;
    logic [15:0] in_disable;
    logic [15:0] pullup_disable;
  } acp_pin_s;

endpackage

// File: core/acp_ctrl.sv
/*
  Converter configuration and analog pin-control registers.
  Holds the configuration register, the two pin-control registers,
  the converter clock selection and divider, and the per-pin overrides.
  Assumes a synchronous register master, an alternate clock and an
  internal asynchronous clock that arrive as ordinary sampled levels.
*/
// Function
// (R01) Configuration bit 7 picks high speed at 0 and low power at 1.
// (R02) Bits 6:5 divide the chosen input clock by 1, 2, 4 or 8.
// (R03) Configuration bit 4 chooses between short and long sampling.
// (R04) A sample-time bit of 0 means short sampling and 1 means long.
// (R05) Bits 3:2 give 8-bit at 00 and 10-bit at 10, with 01 and 11 reserved.
// (R06) Bits 1:0 select bus, halved bus, alternate or internal async clock.
// (R07) A pin-control bit of 1 takes the pin from the port for analog use.
// (R08) First pin-control register bits 0 to 7 map to channels 0 to 7.
// (R09) Second pin-control register bits 0 to 7 map to channels 8 to 15.
// (R10) A set pin bit forces output high impedance, input off, pullup off.
module acp_ctrl (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic nrst_i,
  // Register port.
  input wire logic [1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // Clock sources.
  input wire logic alternate_clock_i,
  input wire logic internal_async_clock_i,
  // Converter side.
  output logic converter_clock_o,
  output acp_pkg::acp_conv_s conv_o,
  // Pin side.
  output acp_pkg::acp_pin_s pin_o
);

  logic [7:0] cfg_ff;
  logic [7:0] pin_lo_ff;
  logic [7:0] pin_hi_ff;
  logic [7:0] rdata_ff;
  logic half_ff;
  logic bus_ph_ff;
  logic src_clk;
  logic src_prev_ff;
  logic [2:0] div_cnt_ff;
  logic [2:0] nxt_div_cnt;
  logic [2:0] div_term;
  logic conv_clk_ff;
  logic [15:0] analog_sel;

  // Software-written configuration register.
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      cfg_ff <= acp_pkg::ACP_CFG_RST;
    else if (wr_i && addr_i == acp_pkg::ACP_OFF_CFG)
      cfg_ff <= wdata_i;
  end

  // Pin-control registers; reset leaves every pin under port control.
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      pin_lo_ff <= acp_pkg::ACP_PIN_RST;
      pin_hi_ff <= acp_pkg::ACP_PIN_RST;
    end
    else if (wr_i)
    begin
      if (addr_i == acp_pkg::ACP_OFF_PIN_LO)
        pin_lo_ff <= wdata_i;
      if (addr_i == acp_pkg::ACP_OFF_PIN_HI)
        pin_hi_ff <= wdata_i;
    end
  end

  // Read data stands only in the cycle after the strobe; unmapped reads zero.
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      rdata_ff <= acp_pkg::ACP_UNMAPPED_RD;
    else if (rd_i)
    begin
      unique case (addr_i)
        acp_pkg::ACP_OFF_CFG: rdata_ff <= cfg_ff;
        acp_pkg::ACP_OFF_PIN_LO: rdata_ff <= pin_lo_ff;
        acp_pkg::ACP_OFF_PIN_HI: rdata_ff <= pin_hi_ff;
        default: rdata_ff <= acp_pkg::ACP_UNMAPPED_RD;
      endcase
    end
    else
      rdata_ff <= acp_pkg::ACP_UNMAPPED_RD;
  end
  assign rdata_o = rdata_ff;

  // Decoded settings; the mode flag warns the core of a reserved encoding.
  always_comb
  begin
    conv_o.low_power = cfg_ff[acp_pkg::ACP_LOW_POWER_BIT]; // R01
    conv_o.long_sample = cfg_ff[acp_pkg::ACP_LONG_SAMPLE_BIT]; // R03 R04
    conv_o.ten_bit = (cfg_ff[acp_pkg::ACP_MODE_HI:acp_pkg::ACP_MODE_LO]
                      == acp_pkg::ACP_MODE_10BIT); // R05
    conv_o.mode_reserved = (cfg_ff[acp_pkg::ACP_MODE_HI:acp_pkg::ACP_MODE_LO]
                            != acp_pkg::ACP_MODE_8BIT) && !conv_o.ten_bit; // R05
    conv_o.clock_source = cfg_ff[acp_pkg::ACP_CLK_HI:acp_pkg::ACP_CLK_LO]; // R06
    conv_o.clock_divide = cfg_ff[acp_pkg::ACP_DIV_HI:acp_pkg::ACP_DIV_LO]; // R02
  end

  // Bus-rate phase and the halved bus clock, which changes on every second phase.
  // The bus clock itself changes level each cycle, so the half rate needs two cycles.
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      bus_ph_ff <= 1'b0;
      half_ff <= 1'b0;
    end
    else
    begin
      bus_ph_ff <= ~bus_ph_ff;
      half_ff <= half_ff ^ bus_ph_ff; // R06
    end
  end

  // Source select; the bus clock itself is modelled as a level toggling every cycle.
  always_comb
  begin
    unique case (conv_o.clock_source) // R06
      acp_pkg::ACP_SRC_BUS: src_clk = ~src_prev_ff;
      acp_pkg::ACP_SRC_BUS_HALF: src_clk = half_ff;
      acp_pkg::ACP_SRC_ALT: src_clk = alternate_clock_i;
      acp_pkg::ACP_SRC_ASYNC: src_clk = internal_async_clock_i;
    endcase
  end

  // Edge history of the selected source level.
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      src_prev_ff <= 1'b0;
    else
      src_prev_ff <= src_clk;
  end

  // Divider counts source edges; the output toggles every ratio source edges.
  // Sampling the sources limits the result to half the bus rate.
  // A divide change in mid-count may stretch one phase of the output once.
  always_comb
  begin
    unique case (conv_o.clock_divide) // R02
      acp_pkg::ACP_DIV_1: div_term = acp_pkg::ACP_TERM_DIV1;
      acp_pkg::ACP_DIV_2: div_term = acp_pkg::ACP_TERM_DIV2;
      acp_pkg::ACP_DIV_4: div_term = acp_pkg::ACP_TERM_DIV4;
      acp_pkg::ACP_DIV_8: div_term = acp_pkg::ACP_TERM_DIV8;
    endcase
    nxt_div_cnt = div_cnt_ff + acp_pkg::ACP_CNT_ONE;
  end

  // Any source edge advances the counter; terminal count toggles the output.
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      div_cnt_ff <= acp_pkg::ACP_CNT_ZERO;
      conv_clk_ff <= 1'b0;
    end
    else if (src_clk != src_prev_ff)
    begin
      if (nxt_div_cnt == div_term || conv_o.clock_divide == acp_pkg::ACP_DIV_1) // R02
      begin
        div_cnt_ff <= acp_pkg::ACP_CNT_ZERO;
        conv_clk_ff <= ~conv_clk_ff;
      end
      else
        div_cnt_ff <= nxt_div_cnt;
    end
  end
  assign converter_clock_o = conv_clk_ff;

  // One pin override per channel, each bit mapped straight across.
  assign analog_sel = {pin_hi_ff, pin_lo_ff}; // R08 R09
  generate
    for (genvar i = 0; i < acp_pkg::ACP_PINS; i++)
    begin : g_pin
      assign pin_o.out_hiz[i] = analog_sel[i]; // R07 R10
      assign pin_o.in_disable[i] = analog_sel[i]; // R07 R10
      assign pin_o.pullup_disable[i] = analog_sel[i]; // R10
    end
  endgenerate

  a_pin_hiz_map: assert property (@(posedge clk_i) disable iff (!nrst_i) // R10
    wr_i && addr_i == acp_pkg::ACP_OFF_PIN_LO |=> pin_o.out_hiz[7:0] == $past(wdata_i))
    else $error("Low pin bank did not follow write.");
  a_pin_high_map: assert property (@(posedge clk_i) disable iff (!nrst_i) // R09
    wr_i && addr_i == acp_pkg::ACP_OFF_PIN_HI |=> pin_o.in_disable[15:8] == $past(wdata_i))
    else $error("High pin bank did not follow write.");
  a_low_power_sel: assert property (@(posedge clk_i) disable iff (!nrst_i) // R01
    wr_i && addr_i == acp_pkg::ACP_OFF_CFG |=> conv_o.low_power == $past(wdata_i[7]))
    else $error("Low power select mismatch.");
  a_sample_sel: assert property (@(posedge clk_i) disable iff (!nrst_i) // R04
    wr_i && addr_i == acp_pkg::ACP_OFF_CFG |=> conv_o.long_sample == $past(wdata_i[4]))
    else $error("Sample select mismatch.");
  a_mode_ten: assert property (@(posedge clk_i) disable iff (!nrst_i) // R05
    wr_i && addr_i == acp_pkg::ACP_OFF_CFG && wdata_i[3:2] == 2'h2 |=> conv_o.ten_bit)
    else $error("Ten bit mode not selected.");
  a_mode_eight: assert property (@(posedge clk_i) disable iff (!nrst_i) // R05
    wr_i && addr_i == acp_pkg::ACP_OFF_CFG && wdata_i[3:2] == 2'h0
    |=> !conv_o.ten_bit && !conv_o.mode_reserved)
    else $error("Eight bit mode not selected.");
  a_src_sel: assert property (@(posedge clk_i) disable iff (!nrst_i) // R06
    wr_i && addr_i == acp_pkg::ACP_OFF_CFG |=> conv_o.clock_source == $past(wdata_i[1:0]))
    else $error("Clock source mismatch.");
  a_div_one: assert property (@(posedge clk_i) disable iff (!nrst_i) // R02
    conv_o.clock_source == acp_pkg::ACP_SRC_BUS && conv_o.clock_divide == acp_pkg::ACP_DIV_1
    && $stable(conv_o.clock_divide) && $stable(conv_o.clock_source)
    |=> conv_clk_ff != $past(conv_clk_ff))
    else $error("Divide by one did not toggle.");
  // The halved source must hold each level for two bus cycles.
  a_half_rate: assert property (@(posedge clk_i) disable iff (!nrst_i) // R06
    $changed(half_ff) |=> $stable(half_ff))
    else $error("Halved bus clock changed on consecutive cycles.");
  a_read_back: assert property (@(posedge clk_i) disable iff (!nrst_i) // R07
    rd_i && addr_i == acp_pkg::ACP_OFF_PIN_LO && !wr_i |=> rdata_o == pin_o.pullup_disable[7:0])
    else $error("Pin register read back mismatch.");

endmodule

// File: testbench/testbench.sv
/*
  Self-checking bench for the converter configuration and pin-control block.
  Assumes the register port answers reads one cycle after the strobe and
  that clock sources are plain levels sampled on the bus clock.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, nrst_i, wr_i, rd_i, alternate_clock_i, internal_async_clock_i;
  logic [1:0] addr_i;
  logic [7:0] wdata_i, rdata_o, d, c;
  logic converter_clock_o;
  logic [2:0] slow_cnt;
  acp_pkg::acp_conv_s conv_o;
  acp_pkg::acp_pin_s pin_o;
  acp_pkg::acp_conv_s ec;
  logic [7:0] regs [0:2];
  int miscompares = 0;
  int checks_done = 0;
  int seed = 30757;
  int n;
  int rate [0:3] = '{1, 2, 1, 2};

  acp_ctrl acp_ctrl_inst (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .alternate_clock_i(alternate_clock_i),
    .internal_async_clock_i(internal_async_clock_i), .converter_clock_o(converter_clock_o),
    .conv_o(conv_o), .pin_o(pin_o));

  // The bus clock at 200 MHz.
  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // Alternate source changes every cycle, async source every second cycle.
  always @(posedge clk_i)
  begin
    alternate_clock_i <= ~alternate_clock_i;
    slow_cnt <= slow_cnt + 3'h1;
    internal_async_clock_i <= slow_cnt[1];
  end

  // Register writes update the model; offset 3 holds nothing.
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    if (a != 2'h3) regs[a] = v;
  endtask

  // Read data is taken in the single cycle after the strobe.
  task automatic rd(input logic [1:0] a, output logic [7:0] v);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask

  task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD rdata t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_out(input logic [47:0] got, input logic [47:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD output t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_cnt(input int got, input int exp);
    checks_done++;
    if (got > exp + 1 || got < exp - 1)
    begin
      miscompares++;
      $display("BAD toggles t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Compares decoded settings and pin overrides with the model registers.
  task automatic chk_outs();
    #1 ec = '0;
    ec.low_power = regs[0][7];
    ec.long_sample = regs[0][4];
    ec.ten_bit = (regs[0][3:2] == 2'h2);
    ec.mode_reserved = regs[0][2];
    ec.clock_source = regs[0][1:0];
    ec.clock_divide = regs[0][6:5];
    chk_out({40'h0, conv_o}, {40'h0, ec});
    chk_out(pin_o, {3{regs[2], regs[1]}});
  endtask

  task automatic results();
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Watchdog so a hang still reaches the verdict.
  initial
  begin
    #400000;
    miscompares++;
    results();
  end

  // Main sequence: reset, every encoding, pins, unmapped access, mid-run reset.
  initial
  begin
    {nrst_i, addr_i, wdata_i, wr_i, rd_i} = '0;
    {alternate_clock_i, internal_async_clock_i, slow_cnt} = '0;
    regs = '{8'h00, 8'h00, 8'h00};
    repeat (20) @(posedge clk_i);
    nrst_i <= 1'b1;
    chk_outs();
    for (int i = 0; i < 16; i++)
    begin
      c = $random(seed);
      c[1:0] = i[1:0];
      c[6:5] = i[3:2];
      c[3:2] = i[1:0] ^ i[3:2];
      wr(2'h0, c);
      chk_outs();
      rd(2'h0, d);
      chk_rd(d, c);
      // Divided clock toggles once per divide count of source level changes.
      n = 0;
      repeat (8) @(posedge clk_i);
      #1 d[0] = converter_clock_o;
      repeat (64)
      begin
        @(posedge clk_i);
        #1 if (converter_clock_o !== d[0]) n++;
        d[0] = converter_clock_o;
      end
      chk_cnt(n, 64 / (rate[i % 4] * (1 << (i / 4))));
    end
    for (int i = 0; i < 8; i++)
    begin
      wr(2'h1, $random(seed));
      wr(2'h2, $random(seed));
      chk_outs();
      rd(2'h1, d);
      chk_rd(d, regs[1]);
      rd(2'h2, d);
      chk_rd(d, regs[2]);
    end
    // Offset 3 takes no write and reads back the fixed value.
    wr(2'h3, 8'hFF);
    chk_outs();
    rd(2'h3, d);
    chk_rd(d, acp_pkg::ACP_UNMAPPED_RD);
    // Read data stands for one cycle only and then returns to zero.
    rd(2'h1, d);
    @(posedge clk_i);
    #1 chk_rd(rdata_o, acp_pkg::ACP_UNMAPPED_RD);
    // A reset in mid-run must clear every register.
    @(posedge clk_i);
    nrst_i <= 1'b0;
    regs = '{8'h00, 8'h00, 8'h00};
    repeat (2) @(posedge clk_i);
    chk_outs();
    chk_out({47'h0, converter_clock_o}, 48'h0);
    @(posedge clk_i);
    nrst_i <= 1'b1;
    rd(2'h2, d);
    chk_rd(d, acp_pkg::ACP_PIN_RST);
    results();
  end
endmodule
